/* File: src/btmr_pkg.sv */
// Shared constants, field positions and state codes of the basic timer
//------------------------------------------------------------------------------
// Overview of operation
// - Hardware counts; firmware may overwrite count
// - Count read captured whole into holding buffer
// - Narrow instance: count bits 31:16 read zero
// - Wide instance: all 32 count bits writable
// - Automatic restart loads preload into counter
// - Preload width equals counter width
// - Wide instance: all 32 preload bits writable
// - Limit reached sets status bit 0
// - Enable bit 0 gates event onto interrupt
// - Block reset is system OR soft reset
// - Restart reloads; otherwise enter done state
// - Up saturates all ones; down at zero
// - Start clears divider, interrupts; limit without restart clears start
//------------------------------------------------------------------------------
package btmr_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int DIV_W = 16;

  // Register offsets
  localparam logic [7:0] OFF_COUNT = 8'h00;
  localparam logic [7:0] OFF_RELOAD = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_IRQEN = 8'h0c;
  localparam logic [7:0] OFF_CTRL = 8'h10;

  // Control register fields
  localparam int CTRL_ENABLE = 0;
  localparam int CTRL_COUNT_UP = 2;
  localparam int CTRL_AUTO_RESTART = 3;
  localparam int CTRL_SOFT_RESET = 4;
  localparam int CTRL_START = 5;
  localparam int CTRL_RELOAD = 6;
  localparam int CTRL_HALT = 7;
  localparam int CTRL_PRESCALE_LSB = 16;

  // Status and enable field
  localparam int EVENT_BIT = 0;

  // Reset values and width masks
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
  localparam logic [15:0] RESET_DIV = 16'h0000;
  localparam logic [31:0] MASK_WIDE = 32'hffff_ffff;
  localparam logic [31:0] MASK_NARROW = 32'h0000_ffff;

  typedef enum logic [1:0] {
    BTMR_IDLE = 2'b00,
    BTMR_RUN = 2'b01,
    BTMR_DONE = 2'b11
  } btmr_state_e;

endpackage

/* File: src/btmr_prescale.sv */
// Clock-enable divider that paces the counter
`timescale 1ns/1ns
module btmr_prescale (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // Control
  input wire logic clr,
  input wire logic run,
  input wire logic [btmr_pkg::DIV_W-1:0] div,
  // Pace output
  output logic tick
);

  logic [btmr_pkg::DIV_W-1:0] cnt_ff;
  logic [btmr_pkg::DIV_W-1:0] nxt_cnt;

  // One tick every div+1 clocks; a change of div mid-count alters one period, and a drop below the count ticks at once
  assign tick = run && !clr && (cnt_ff >= div);

  always_comb begin
    nxt_cnt = cnt_ff;
    if (clr || !run) begin
      nxt_cnt = btmr_pkg::RESET_DIV;
    end else if (tick) begin
      nxt_cnt = btmr_pkg::RESET_DIV;
    end else begin
      nxt_cnt = cnt_ff + 16'h0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff <= 16'h0000;
    end else if (ce) begin
      cnt_ff <= nxt_cnt;
    end
  end

endmodule

/* File: src/btmr_rdbuf.sv */
// Read data register with the coherent count snapshot
`timescale 1ns/1ns
module btmr_rdbuf (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic clr,
  // Read request
  input wire logic load,
  input wire logic capture,
  input wire logic use_snap,
  input wire logic [31:0] live_count,
  input wire logic [31:0] rd_word,
  // Read data
  output logic [31:0] prdata
);

  logic [31:0] snap_ff;
  logic [31:0] nxt_snap;
  logic [31:0] data_ff;
  logic [31:0] nxt_data;

  assign prdata = data_ff;

  // Byte 0 read refreshes the snapshot, upper byte reads replay it
  always_comb begin
    nxt_snap = snap_ff;
    nxt_data = data_ff;
    if (clr) begin
      nxt_snap = btmr_pkg::RESET_WORD;
      nxt_data = btmr_pkg::RESET_WORD;
    end else if (load) begin
      if (capture) begin
        nxt_snap = live_count;
      end
      nxt_data = use_snap ? snap_ff : rd_word;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      snap_ff <= 32'h0000_0000;
      data_ff <= 32'h0000_0000;
    end else if (ce) begin
      snap_ff <= nxt_snap;
      data_ff <= nxt_data;
    end
  end

endmodule

/* File: src/btmr_core.sv */
// Basic 16/32-bit timer with APB register slave and interrupt
`timescale 1ns/1ns
module btmr_core #(
  parameter bit WIDE32 = 1'b1
) (
  // Clock, reset and clock enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [btmr_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Interrupt
  output logic timer_irq
);

  //----------------------------------------------------------------------------
  // Width masks
  //----------------------------------------------------------------------------
  localparam logic [31:0] CNT_MASK = WIDE32 ? btmr_pkg::MASK_WIDE : btmr_pkg::MASK_NARROW;

  function automatic logic [31:0] merge_bytes(input logic [31:0] old_val,
                                              input logic [31:0] new_val,
                                              input logic [3:0] strb);
    logic [31:0] res;
    res = old_val;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = new_val[8*b +: 8];
      end
    end
    return res;
  endfunction

  //----------------------------------------------------------------------------
  // State
  //----------------------------------------------------------------------------
  logic [31:0] count_ff;
  logic [31:0] nxt_count;
  logic [31:0] preload_ff;
  logic [31:0] nxt_preload;
  logic [15:0] prescale_ff;
  logic [15:0] nxt_prescale;
  logic halt_ff;
  logic nxt_halt;
  logic reload_ff;
  logic nxt_reload;
  logic start_ff;
  logic nxt_start;
  logic soft_ff;
  logic nxt_soft;
  logic auto_ff;
  logic nxt_auto;
  logic up_ff;
  logic nxt_up;
  logic enable_ff;
  logic nxt_enable;
  btmr_pkg::btmr_state_e state_ff;
  btmr_pkg::btmr_state_e nxt_state;
  logic status_ff;
  logic nxt_status;
  logic irqen_ff;
  logic nxt_irqen;
  logic irq_ff;
  logic nxt_irq;

  //----------------------------------------------------------------------------
  // Bus decode
  //----------------------------------------------------------------------------
  logic [7:0] word_addr;
  logic wr_acc;
  logic rd_setup;
  logic hit_count;
  logic hit_reload;
  logic hit_status;
  logic hit_irqen;
  logic hit_ctrl;
  logic mapped;
  logic [31:0] wdata_ctrl;
  logic [31:0] ctrl_word;
  logic [31:0] rd_word;
  logic rd_buf_ce;
  logic rd_buf_clr;

  assign word_addr = {paddr[7:2], 2'b00};
  assign hit_count = (word_addr == btmr_pkg::OFF_COUNT);
  assign hit_reload = (word_addr == btmr_pkg::OFF_RELOAD);
  assign hit_status = (word_addr == btmr_pkg::OFF_STATUS);
  assign hit_irqen = (word_addr == btmr_pkg::OFF_IRQEN);
  assign hit_ctrl = (word_addr == btmr_pkg::OFF_CTRL);
  assign mapped = hit_count | hit_reload | hit_status | hit_irqen | hit_ctrl;

  // Zero wait states; a frozen block stretches the access instead of losing it
  assign pready = ce;
  assign pslverr = psel & penable & ~mapped;
  assign wr_acc = psel & penable & pwrite & ce & mapped;
  // No ce term: APB never stretches a setup cycle, so a frozen read setup would be lost
  assign rd_setup = psel & ~penable & ~pwrite;

  //----------------------------------------------------------------------------
  // Register images
  //----------------------------------------------------------------------------
  // Control writes merge by byte lane so a partial write keeps the other fields
  assign wdata_ctrl = merge_bytes(ctrl_word, pwdata, pstrb);

  always_comb begin
    ctrl_word = 32'h0000_0000;
    ctrl_word[btmr_pkg::CTRL_PRESCALE_LSB +: 16] = prescale_ff;
    ctrl_word[btmr_pkg::CTRL_HALT] = halt_ff;
    ctrl_word[btmr_pkg::CTRL_RELOAD] = reload_ff;
    ctrl_word[btmr_pkg::CTRL_START] = start_ff;
    ctrl_word[btmr_pkg::CTRL_AUTO_RESTART] = auto_ff;
    ctrl_word[btmr_pkg::CTRL_COUNT_UP] = up_ff;
    ctrl_word[btmr_pkg::CTRL_ENABLE] = enable_ff;
  end

  //----------------------------------------------------------------------------
  // Register read mux
  //----------------------------------------------------------------------------
  // Reserved bits and unmapped words read zero
  always_comb begin
    rd_word = 32'h0000_0000;
    if (hit_count) begin
      rd_word = count_ff & CNT_MASK;
    end else if (hit_reload) begin
      rd_word = preload_ff & CNT_MASK;
    end else if (hit_status) begin
      rd_word[btmr_pkg::EVENT_BIT] = status_ff;
    end else if (hit_irqen) begin
      rd_word[btmr_pkg::EVENT_BIT] = irqen_ff;
    end else if (hit_ctrl) begin
      rd_word = ctrl_word;
    end
  end

  //----------------------------------------------------------------------------
  // Read data path
  //----------------------------------------------------------------------------
  // Trade-off: the read word and snapshot may load while the timer is frozen; the
  // count cannot move then, so the snapshot stays coherent
  assign rd_buf_ce = ce | rd_setup;
  assign rd_buf_clr = soft_ff & ce;

  btmr_rdbuf u_rdbuf (
    .pclk(pclk),
    .presetn(presetn),
    .ce(rd_buf_ce),
    .clr(rd_buf_clr),
    .load(rd_setup),
    .capture(hit_count && (paddr[1:0] == 2'b00)),
    .use_snap(hit_count && (paddr[1:0] != 2'b00)),
    .live_count(count_ff & CNT_MASK),
    .rd_word(rd_word),
    .prdata(prdata)
  );

  //----------------------------------------------------------------------------
  // Prescaler
  //----------------------------------------------------------------------------
  logic run;
  logic tick;
  logic start_set;
  logic div_clr;

  assign run = start_ff & enable_ff & ~halt_ff & (state_ff == btmr_pkg::BTMR_RUN);
  assign start_set = wr_acc & hit_ctrl & pstrb[0] & pwdata[btmr_pkg::CTRL_START] & ~start_ff;
  // Halt holds the divider clear so a resume starts with a full period
  assign div_clr = soft_ff | start_set | halt_ff;

  btmr_prescale u_prescale (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .clr(div_clr),
    .run(run),
    .div(prescale_ff),
    .tick(tick)
  );

  //----------------------------------------------------------------------------
  // Counter and control
  //----------------------------------------------------------------------------
  logic [31:0] stepped;
  logic [31:0] limit;
  logic hit_limit;
  logic limit_event;

  assign stepped = (up_ff ? (count_ff + 32'h0000_0001) : (count_ff - 32'h0000_0001)) & CNT_MASK;
  assign limit = up_ff ? CNT_MASK : 32'h0000_0000;
  // A count already at the limit fires on the next tick, so a zero preload still wraps
  assign hit_limit = ((count_ff & CNT_MASK) == limit) || (stepped == limit);
  assign limit_event = run & tick & hit_limit;

  always_comb begin
    nxt_count = count_ff;
    nxt_preload = preload_ff;
    nxt_prescale = prescale_ff;
    nxt_halt = halt_ff;
    nxt_reload = 1'b0;
    nxt_start = start_ff;
    nxt_soft = 1'b0;
    nxt_auto = auto_ff;
    nxt_up = up_ff;
    nxt_enable = enable_ff;
    nxt_state = state_ff;
    if (soft_ff) begin
      // Soft reset returns every register to zero one cycle after the request
      nxt_count = btmr_pkg::RESET_WORD;
      nxt_preload = btmr_pkg::RESET_WORD;
      nxt_prescale = btmr_pkg::RESET_DIV;
      nxt_halt = 1'b0;
      nxt_start = 1'b0;
      nxt_auto = 1'b0;
      nxt_up = 1'b0;
      nxt_enable = 1'b0;
      nxt_state = btmr_pkg::BTMR_IDLE;
    end else begin
      unique case (state_ff)
        btmr_pkg::BTMR_IDLE, btmr_pkg::BTMR_RUN, btmr_pkg::BTMR_DONE: begin
          nxt_state = state_ff;
        end
        default: begin
          // The spare code is never entered; leave it for idle rather than hang
          nxt_state = btmr_pkg::BTMR_IDLE;
        end
      endcase
      // Counting steps
      if (limit_event) begin
        if (auto_ff) begin
          nxt_count = preload_ff & CNT_MASK;
        end else begin
          nxt_count = limit;
          nxt_start = 1'b0;
          nxt_state = btmr_pkg::BTMR_DONE;
        end
      end else if (reload_ff && start_ff) begin
        nxt_count = preload_ff & CNT_MASK;
      end else if (run && tick) begin
        nxt_count = stepped;
      end
      // Firmware writes win over the counter; a write while running is unsafe
      if (wr_acc && hit_count) begin
        nxt_count = merge_bytes(count_ff, pwdata, pstrb) & CNT_MASK;
      end
      if (wr_acc && hit_reload) begin
        nxt_preload = merge_bytes(preload_ff, pwdata, pstrb) & CNT_MASK;
      end
      if (wr_acc && hit_ctrl) begin
        nxt_prescale = wdata_ctrl[btmr_pkg::CTRL_PRESCALE_LSB +: 16];
        nxt_halt = wdata_ctrl[btmr_pkg::CTRL_HALT];
        nxt_reload = pstrb[0] & pwdata[btmr_pkg::CTRL_RELOAD];
        nxt_soft = pstrb[0] & pwdata[btmr_pkg::CTRL_SOFT_RESET];
        nxt_auto = wdata_ctrl[btmr_pkg::CTRL_AUTO_RESTART];
        nxt_up = wdata_ctrl[btmr_pkg::CTRL_COUNT_UP];
        nxt_enable = wdata_ctrl[btmr_pkg::CTRL_ENABLE];
        nxt_start = wdata_ctrl[btmr_pkg::CTRL_START];
        if (start_set) begin
          nxt_state = btmr_pkg::BTMR_RUN;
        end else if (!wdata_ctrl[btmr_pkg::CTRL_START]) begin
          nxt_state = btmr_pkg::BTMR_IDLE;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_ff <= 32'h0000_0000;
      preload_ff <= 32'h0000_0000;
      prescale_ff <= 16'h0000;
      halt_ff <= 1'b0;
      reload_ff <= 1'b0;
      start_ff <= 1'b0;
      soft_ff <= 1'b0;
      auto_ff <= 1'b0;
      up_ff <= 1'b0;
      enable_ff <= 1'b0;
      state_ff <= btmr_pkg::BTMR_IDLE;
    end else if (ce) begin
      count_ff <= nxt_count;
      preload_ff <= nxt_preload;
      prescale_ff <= nxt_prescale;
      halt_ff <= nxt_halt;
      reload_ff <= nxt_reload;
      start_ff <= nxt_start;
      soft_ff <= nxt_soft;
      auto_ff <= nxt_auto;
      up_ff <= nxt_up;
      enable_ff <= nxt_enable;
      state_ff <= nxt_state;
    end
  end

  //----------------------------------------------------------------------------
  // Event status and interrupt
  //----------------------------------------------------------------------------
  logic ev_clear;

  assign ev_clear = wr_acc & hit_status & pstrb[0] & pwdata[btmr_pkg::EVENT_BIT];
  assign timer_irq = irq_ff;

  always_comb begin
    nxt_status = status_ff;
    nxt_irqen = irqen_ff;
    if (soft_ff) begin
      nxt_status = 1'b0;
      nxt_irqen = 1'b0;
    end else begin
      if (auto_ff) begin
        // Restart mode: flag is a one-cycle pulse per limit
        nxt_status = limit_event;
      end else if (limit_event) begin
        nxt_status = 1'b1;
      // A limit in the same cycle as a clear keeps the flag set
      end else if (ev_clear || start_set) begin
        nxt_status = 1'b0;
      end
      if (wr_acc && hit_irqen && pstrb[0]) begin
        nxt_irqen = pwdata[btmr_pkg::EVENT_BIT];
      end
    end
    // Built from next values so the line rises with the status bit, not a cycle later
    nxt_irq = nxt_status & nxt_irqen;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_ff <= 1'b0;
      irqen_ff <= 1'b0;
      irq_ff <= 1'b0;
    end else if (ce) begin
      status_ff <= nxt_status;
      irqen_ff <= nxt_irqen;
      irq_ff <= nxt_irq;
    end
  end

endmodule

/* File: verification/btmr_chk.sv */
// Port-level assertions of the basic timer core
`timescale 1ns/1ns
module btmr_chk #(
  parameter bit WIDE32 = 1'b1
) (
  // Clock, reset and enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [btmr_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Interrupt
  input wire logic timer_irq
);
  // Shadow of the enable bit; soft reset lands one edge after its write
  logic en_ff, soft_ff, nxt_en, nxt_soft, acc, rd_acc;
  assign acc = psel && penable && ce;
  assign rd_acc = psel && penable && !pwrite;
  always_comb begin
    nxt_soft = acc && pwrite && paddr == 8'h10 && pstrb[0] && pwdata[4];
    nxt_en = soft_ff ? 1'b0 : en_ff;
    if (acc && pwrite && paddr == 8'h0c && pstrb[0]) begin
      nxt_en = pwdata[0];
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_ff <= 1'b0;
      soft_ff <= 1'b0;
    end else if (ce) begin
      en_ff <= nxt_en;
      soft_ff <= nxt_soft;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_err_map; psel && penable |-> pslverr == (paddr[7:2] > 6'd4); endproperty
  a_err_map: assert property (p_err_map) else $error("pslverr vs map");
  property p_err_phase; pslverr |-> psel && penable; endproperty
  a_err_phase: assert property (p_err_phase) else $error("pslverr out of phase");
  property p_unmap_rd; rd_acc && paddr[7:2] > 6'd4 |-> prdata == 32'h0; endproperty
  a_unmap_rd: assert property (p_unmap_rd) else $error("unmapped read data");
  property p_narrow; rd_acc && !WIDE32 && paddr[7:3] == 5'h0 |-> prdata[31:16] == 16'h0;
  endproperty
  a_narrow: assert property (p_narrow) else $error("narrow upper bits");
  property p_stat_bits; rd_acc && paddr[7:3] == 5'h1 |-> prdata[31:1] == 31'h0; endproperty
  a_stat_bits: assert property (p_stat_bits) else $error("status upper bits");
  property p_irq_en; timer_irq |-> en_ff; endproperty
  a_irq_en: assert property (p_irq_en) else $error("irq while disabled");
  property p_rst; $rose(presetn) |-> !timer_irq && prdata == 32'h0; endproperty
  a_rst: assert property (p_rst) else $error("outputs after reset");
  property p_hold; psel && penable && !pready |=> $stable(prdata); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_ready; pready == ce; endproperty
  a_ready: assert property (p_ready) else $error("pready vs ce");
  c_irq: cover property ($rose(timer_irq));
  c_err: cover property (pslverr);
  c_snap: cover property (rd_acc && paddr == 8'h01);
endmodule

/* File: verification/tb_top.sv */
// Self-checking bench for a wide and a narrow basic timer core
`timescale 1ns/1ns
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin fails++; \
  $display("mismatch at %0t: got %h exp %h", $time, g, e); end end
module tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic ce = 1'b1;
  logic ce_rnd = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [1:0] psel = 2'b00;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hf;
  wire [31:0] prd0, prd1;
  wire [1:0] rdy, err, irq;
  logic [31:0] rdat, v;
  integer seed = 32'hd1516db8;
  int fails = 0;
  int n_tests = 0;
  int n, hi, rises;
  always #5 pclk = ~pclk;
  // Random stalls only while the timers stand still
  always @(posedge pclk) ce <= ce_rnd ? 1'($random(seed)) : 1'b1;
  btmr_core #(.WIDE32(1'b1)) i_dut (.pclk(pclk), .presetn(presetn), .ce(ce),
    .psel(psel[0]), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prd0), .pready(rdy[0]), .pslverr(err[0]), .timer_irq(irq[0]));
  btmr_core #(.WIDE32(1'b0)) i_dut_n (.pclk(pclk), .presetn(presetn), .ce(ce),
    .psel(psel[1]), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prd1), .pready(rdy[1]), .pslverr(err[1]), .timer_irq(irq[1]));
  //----------------------------------------------------------------------------
  // Bus tasks
  //----------------------------------------------------------------------------
  task automatic apb(input int s, input logic w, input logic [7:0] a, input logic [31:0] d,
    input logic e);
    @(posedge pclk);
    psel[s] <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (rdy[s] !== 1'b1);
    rdat = (s == 1) ? prd1 : prd0;
    `CHK(err[s], e)
    psel <= 2'b00;
    penable <= 1'b0;
  endtask
  task automatic wr(input int s, input logic [7:0] a, input logic [31:0] d);
    apb(s, 1'b1, a, d, 1'b0);
  endtask
  task automatic rd(input int s, input logic [7:0] a, input logic [31:0] x, input logic e);
    apb(s, 1'b0, a, 32'h0, e);
    `CHK(rdat, x)
  endtask
  function automatic logic [31:0] msk(input int s, input logic [31:0] x);
    return s ? (x & 32'h0000ffff) : x;
  endfunction
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  //----------------------------------------------------------------------------
  // Scenarios
  //----------------------------------------------------------------------------
  initial begin
    #100000;
    fails++;
    final_report();
  end
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    for (int s = 0; s < 2; s++) begin
      for (int a = 0; a < 16; a += 4) rd(s, 8'(a), 32'h0, 1'b0);
    end
    $display("test reset done");
    ce_rnd <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      v = (i == 0) ? 32'hffff_ffff : $random(seed);
      for (int s = 0; s < 2; s++) begin
        wr(s, 8'h00, v);
        rd(s, 8'h00, msk(s, v), 1'b0);
        wr(s, 8'h04, ~v);
        rd(s, 8'h04, msk(s, ~v), 1'b0);
      end
    end
    rd(0, 8'h14, 32'h0, 1'b1);
    ce_rnd <= 1'b0;
    $display("test width done");
    for (int p = 0; p < 3; p += 2) begin
      wr(0, 8'h0c, 32'h1);
      wr(0, 8'h00, 32'h3);
      wr(0, 8'h10, {16'(p), 16'h0021});
      n = 0;
      while (irq[0] !== 1'b1 && n < 100) begin
        @(posedge pclk);
        n++;
      end
      `CHK(n, 3 * (p + 1) + 1)
      rd(0, 8'h08, 32'h1, 1'b0);
      rd(0, 8'h00, 32'h0, 1'b0);
      rd(0, 8'h10, {16'(p), 16'h0001}, 1'b0);
      wr(0, 8'h08, 32'h1);
      rd(0, 8'h08, 32'h0, 1'b0);
      `CHK(irq[0], 1'b0)
    end
    wr(0, 8'h0c, 32'h0);
    wr(0, 8'h00, 32'h1);
    wr(0, 8'h10, 32'h21);
    repeat (10) @(posedge pclk);
    `CHK(irq[0], 1'b0)
    rd(0, 8'h08, 32'h1, 1'b0);
    wr(1, 8'h00, 32'hfffd);
    wr(1, 8'h10, 32'h25);
    repeat (10) @(posedge pclk);
    rd(1, 8'h00, 32'hffff, 1'b0);
    rd(1, 8'h08, 32'h1, 1'b0);
    $display("test one-shot done");
    wr(0, 8'h00, 32'h8000_0000);
    wr(0, 8'h10, 32'h21);
    apb(0, 1'b0, 8'h00, 32'h0, 1'b0);
    v = rdat;
    for (int a = 1; a < 4; a++) rd(0, 8'(a), v, 1'b0);
    apb(0, 1'b0, 8'h00, 32'h0, 1'b0);
    `CHK(rdat < v, 1'b1)
    $display("test snapshot done");
    wr(0, 8'h10, 32'h0);
    wr(0, 8'h0c, 32'h1);
    wr(0, 8'h04, 32'd20);
    wr(0, 8'h00, 32'h1);
    wr(0, 8'h10, 32'h29);
    hi = 0;
    rises = 0;
    for (int i = 0; i < 60; i++) begin
      @(posedge pclk);
      hi += (irq[0] === 1'b1);
      rises += (irq[0] === 1'b1 && i > 0 && n == 0);
      n = (irq[0] === 1'b1);
    end
    `CHK(hi, rises)
    `CHK(rises > 1, 1'b1)
    apb(0, 1'b0, 8'h00, 32'h0, 1'b0);
    `CHK(rdat <= 32'd20, 1'b1)
    rd(0, 8'h10, 32'h29, 1'b0);
    $display("test restart done");
    wr(0, 8'h10, 32'h10);
    repeat (2) @(posedge pclk);
    for (int a = 0; a < 20; a += 4) rd(0, 8'(a), 32'h0, 1'b0);
    wr(0, 8'h04, 32'h40);
    wr(0, 8'h00, 32'h5);
    wr(0, 8'h10, 32'ha1);
    repeat (5) @(posedge pclk);
    rd(0, 8'h00, 32'h5, 1'b0);
    wr(0, 8'h10, 32'h61);
    rd(0, 8'h00, 32'h40, 1'b0);
    wr(1, 8'h0c, 32'h1);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rd(1, 8'h00, 32'h0, 1'b0);
    rd(1, 8'h0c, 32'h0, 1'b0);
    $display("test resets done");
    final_report();
  end
endmodule
bind btmr_core btmr_chk #(.WIDE32(WIDE32)) i_chk (.pclk(pclk), .presetn(presetn), .ce(ce),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .timer_irq(timer_irq));
